// ==== hdl/drive_status_regs.vh ====
// Object indices, field positions and reset values for the drive status
// and stop-action block. Definitions only; included by its bare name.
`ifndef DRIVE_STATUS_REGS_VH
`define DRIVE_STATUS_REGS_VH

// ============================================================
// Object indices
`define IDX_DRIVE_STATE_REPORT 16'h6041
`define IDX_QUICK_STOP_ACTION 16'h605a
`define IDX_SHUTDOWN_ACTION 16'h605b
`define IDX_DISABLE_OP_ACTION 16'h605c
`define IDX_HALT_ACTION 16'h605d

// ============================================================
// Reset values of the action codes
`define RST_QUICK_STOP_ACTION 16'h0002
`define RST_SHUTDOWN_ACTION 16'h0001
`define RST_DISABLE_OP_ACTION 16'h0001
`define RST_HALT_ACTION 16'h0001

// ============================================================
// Permitted code sets, one bit per code value 0..15
`define OK_QUICK_STOP_ACTION 16'h00ef
`define OK_SHUTDOWN_ACTION 16'h0003
`define OK_DISABLE_OP_ACTION 16'h0003
`define OK_HALT_ACTION 16'h000e

// ============================================================
// Status word bit positions
`define SW_READY_ON 0
`define SW_SWITCHED_ON 1
`define SW_OP_ENABLED 2
`define SW_FAULT 3
`define SW_VOLTAGE 4
`define SW_QUICK_STOP 5
`define SW_ON_DISABLED 6
`define SW_WARNING 7
`define SW_MFR_LOW 8
`define SW_REMOTE 9
`define SW_TARGET 10
`define SW_INT_LIMIT 11
`define SW_MODE_LOW 12
`define SW_MODE_HIGH 13
`define SW_MFR_MID 14
`define SW_MFR_HIGH 15

// ============================================================
// Control word bit positions
`define CW_FAULT_RESET 7
`define CW_HALT 8

// ============================================================
// Stop ramp selection
`define RAMP_NONE 2'h0
`define RAMP_PROFILE 2'h1
`define RAMP_QUICK 2'h2
`define RAMP_IMMEDIATE 2'h3

`endif

// ==== hdl/action_code_reg.v ====
// One 16-bit stop-action code object with a permitted-value check.
// Assumes write strobes last one cycle and come from the object port.
`timescale 1ns/1ps

module action_code_reg #(
  parameter [15:0] RESET_VAL = 16'h0000,
  parameter [15:0] ALLOWED = 16'h0001
) (
  input wire i_clk_sys,
  input wire i_rst_b,
  input wire i_wr,
  input wire [15:0] i_wdata,
  output wire [15:0] o_code,
  output wire o_reject
);

  reg [15:0] code_r;
  wire legal;

  // ============================================================
  // Value check
  // Only small codes exist; anything above fifteen is out of range
  assign legal = (i_wdata[15:4] == 12'h000) && ALLOWED[i_wdata[3:0]];
  assign o_reject = i_wr && !legal;
  assign o_code = code_r;

  // ============================================================
  // Storage
  always @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      code_r <= RESET_VAL;
    end else if (i_wr && legal) begin
      code_r <= i_wdata;
    end
  end

endmodule

// ==== hdl/drive_status_stop.v ====
// Drive state machine with status word and stop-action selection.
// Assumes the motion core reports standstill, faults and limits as
// levels synchronous to i_clk_sys, and executes the selected ramp.
`timescale 1ns/1ps
`include "drive_status_regs.vh"

// What this block does
// - Bits 0-3,5,6 report drive state machine state; 4 voltage
// - Bit 7 follows warning, clears itself
// - Bit 9 zero until initialization finishes
// - Bit 11 shows internal limit active
// - Bits 10,12,13 mode dependent; 8,14,15 maker
// - Quick-stop code set 0-3,5-7, resets to 2
// - Codes 1-3 ramp, then switch on disabled
// - Codes 5-7 ramp, then stay quick stop
// - Code change during quick stop applies later
// - Quick stop during ramp switches to quick
// - Stop-input ramp keeps its rate
// - Shutdown from enabled obeys shutdown code
// - Disable operation obeys disable-op code
// - Halt bit stops per halt code, stays enabled
// - Fault reset rising edge resets alarm
module drive_status_stop (
  input wire i_clk_sys,
  input wire i_rst_b,
  input wire [15:0] i_ctrl_word,
  input wire i_obj_req,
  input wire i_obj_wr,
  input wire [15:0] i_obj_index,
  input wire [15:0] i_obj_wdata,
  input wire i_init_done,
  input wire i_fault,
  input wire i_warning,
  input wire i_voltage_ok,
  input wire i_int_limit,
  input wire i_target_reached,
  input wire [1:0] i_mode_bits,
  input wire [2:0] i_mfr_bits,
  input wire i_stop_input,
  input wire i_motor_stopped,
  output reg [15:0] o_status_word,
  output reg [15:0] o_obj_rdata,
  output reg o_obj_ack,
  output reg o_obj_err,
  output reg o_excite,
  output reg o_stop_req,
  output reg [1:0] o_ramp_sel,
  output reg o_alarm_reset
);

  // ============================================================
  // States
  localparam [8:0] ST_NOT_READY = 9'h001;
  localparam [8:0] ST_ON_DISABLED = 9'h002;
  localparam [8:0] ST_READY_ON = 9'h004;
  localparam [8:0] ST_SWITCHED_ON = 9'h008;
  localparam [8:0] ST_OP_ENABLED = 9'h010;
  localparam [8:0] ST_OP_STOPPING = 9'h020;
  localparam [8:0] ST_QUICK_STOP = 9'h040;
  localparam [8:0] ST_FAULT_REACT = 9'h080;
  localparam [8:0] ST_FAULT = 9'h100;

  reg [8:0] state_r;
  reg [8:0] state_nxt;
  reg [1:0] ramp_r;
  reg [1:0] ramp_nxt;
  reg by_input_r;
  reg by_input_nxt;
  reg [2:0] qs_code_r;
  reg [2:0] qs_code_nxt;
  reg to_ready_r;
  reg to_ready_nxt;
  reg init_done_r;
  reg fault_rst_prev_r;
  reg [6:0] state_bits;
  reg [15:0] status_nxt;
  reg [15:0] rdata_nxt;
  reg err_nxt;

  wire [15:0] qs_code;
  wire [15:0] sd_code;
  wire [15:0] do_code;
  wire [15:0] halt_code;
  wire qs_rej;
  wire sd_rej;
  wire do_rej;
  wire halt_rej;
  wire do_write;
  wire wr_qs;
  wire wr_sd;
  wire wr_do;
  wire wr_halt;
  wire fault_rst_edge;
  wire cmd_dis_volt;
  wire cmd_qstop;
  wire cmd_shutdown;
  wire cmd_switch_on;
  wire cmd_enable;
  wire ramping;

  // ============================================================
  // Control word decode
  assign cmd_dis_volt = !i_ctrl_word[1];
  assign cmd_qstop = i_ctrl_word[1] && !i_ctrl_word[2];
  assign cmd_shutdown = (i_ctrl_word[2:0] == 3'h6);
  assign cmd_switch_on = (i_ctrl_word[3:0] == 4'h7);
  assign cmd_enable = (i_ctrl_word[3:0] == 4'hf);
  assign fault_rst_edge = i_ctrl_word[`CW_FAULT_RESET] &&
    !fault_rst_prev_r;
  // A ramp already running, not counting one in the holding phase
  assign ramping = (ramp_r != `RAMP_NONE) && !i_motor_stopped;

  // ============================================================
  // Action code objects
  assign do_write = i_obj_req && i_obj_wr;
  assign wr_qs = do_write && (i_obj_index == `IDX_QUICK_STOP_ACTION);
  assign wr_sd = do_write && (i_obj_index == `IDX_SHUTDOWN_ACTION);
  assign wr_do = do_write && (i_obj_index == `IDX_DISABLE_OP_ACTION);
  assign wr_halt = do_write && (i_obj_index == `IDX_HALT_ACTION);

  action_code_reg #(
    .RESET_VAL(`RST_QUICK_STOP_ACTION),
    .ALLOWED(`OK_QUICK_STOP_ACTION)
  ) u_quick_stop_action (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .i_wr(wr_qs),
    .i_wdata(i_obj_wdata),
    .o_code(qs_code),
    .o_reject(qs_rej)
  );

  action_code_reg #(
    .RESET_VAL(`RST_SHUTDOWN_ACTION),
    .ALLOWED(`OK_SHUTDOWN_ACTION)
  ) u_shutdown_action (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .i_wr(wr_sd),
    .i_wdata(i_obj_wdata),
    .o_code(sd_code),
    .o_reject(sd_rej)
  );

  action_code_reg #(
    .RESET_VAL(`RST_DISABLE_OP_ACTION),
    .ALLOWED(`OK_DISABLE_OP_ACTION)
  ) u_disable_op_action (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .i_wr(wr_do),
    .i_wdata(i_obj_wdata),
    .o_code(do_code),
    .o_reject(do_rej)
  );

  action_code_reg #(
    .RESET_VAL(`RST_HALT_ACTION),
    .ALLOWED(`OK_HALT_ACTION)
  ) u_halt_action (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .i_wr(wr_halt),
    .i_wdata(i_obj_wdata),
    .o_code(halt_code),
    .o_reject(halt_rej)
  );

  // ============================================================
  // Drive state machine
  always @* begin
    state_nxt = state_r;
    ramp_nxt = ramp_r;
    by_input_nxt = by_input_r;
    qs_code_nxt = qs_code_r;
    to_ready_nxt = to_ready_r;
    if (i_fault && (state_r != ST_FAULT_REACT) &&
        (state_r != ST_FAULT) && (state_r != ST_NOT_READY)) begin
      state_nxt = ST_FAULT_REACT;
      ramp_nxt = `RAMP_QUICK;
      by_input_nxt = 1'b0;
    end else begin
      case (state_r)
        ST_NOT_READY: begin
          if (init_done_r) begin
            state_nxt = ST_ON_DISABLED;
          end
        end
        ST_ON_DISABLED: begin
          if (cmd_shutdown) begin
            state_nxt = ST_READY_ON;
          end
        end
        ST_READY_ON: begin
          if (cmd_dis_volt || cmd_qstop) begin
            state_nxt = ST_ON_DISABLED;
          end else if (cmd_switch_on || cmd_enable) begin
            state_nxt = ST_SWITCHED_ON;
          end
        end
        ST_SWITCHED_ON: begin
          if (cmd_dis_volt || cmd_qstop) begin
            state_nxt = ST_ON_DISABLED;
          end else if (cmd_shutdown) begin
            state_nxt = ST_READY_ON;
          end else if (cmd_enable) begin
            state_nxt = ST_OP_ENABLED;
          end
        end
        ST_OP_ENABLED, ST_OP_STOPPING: begin
          if (cmd_dis_volt) begin
            state_nxt = ST_ON_DISABLED;
            ramp_nxt = `RAMP_NONE;
            by_input_nxt = 1'b0;
          end else if (cmd_qstop) begin
            // Latch the code so later writes apply only from the next quick stop
            qs_code_nxt = qs_code[2:0];
            if (qs_code[2:0] == 3'h0) begin
              state_nxt = ST_ON_DISABLED;
              ramp_nxt = `RAMP_NONE;
              by_input_nxt = 1'b0;
            end else begin
              state_nxt = ST_QUICK_STOP;
              if (ramping && by_input_r) begin
                ramp_nxt = ramp_r;
              end else if (ramping) begin
                ramp_nxt = `RAMP_QUICK;
              end else begin
                ramp_nxt = qs_code[1:0];
              end
            end
          end else if (state_r == ST_OP_STOPPING) begin
            if (i_motor_stopped) begin
              state_nxt = to_ready_r ? ST_READY_ON : ST_SWITCHED_ON;
              ramp_nxt = `RAMP_NONE;
            end
          end else if (cmd_shutdown) begin
            by_input_nxt = 1'b0;
            if (sd_code[0]) begin
              state_nxt = ST_OP_STOPPING;
              ramp_nxt = `RAMP_PROFILE;
              to_ready_nxt = 1'b1;
            end else begin
              state_nxt = ST_READY_ON;
              ramp_nxt = `RAMP_NONE;
            end
          end else if (cmd_switch_on) begin
            by_input_nxt = 1'b0;
            if (do_code[0]) begin
              state_nxt = ST_OP_STOPPING;
              ramp_nxt = `RAMP_PROFILE;
              to_ready_nxt = 1'b0;
            end else begin
              state_nxt = ST_SWITCHED_ON;
              ramp_nxt = `RAMP_NONE;
            end
          end else if (i_stop_input) begin
            ramp_nxt = `RAMP_PROFILE;
            by_input_nxt = 1'b1;
          end else if (i_ctrl_word[`CW_HALT]) begin
            ramp_nxt = halt_code[1:0];
            by_input_nxt = 1'b0;
          end else begin
            ramp_nxt = `RAMP_NONE;
            by_input_nxt = 1'b0;
          end
        end
        ST_QUICK_STOP: begin
          if (cmd_dis_volt) begin
            state_nxt = ST_ON_DISABLED;
            ramp_nxt = `RAMP_NONE;
            by_input_nxt = 1'b0;
          end else if (i_motor_stopped) begin
            if (!qs_code_r[2]) begin
              state_nxt = ST_ON_DISABLED;
              ramp_nxt = `RAMP_NONE;
              by_input_nxt = 1'b0;
            end else if (cmd_enable) begin
              state_nxt = ST_OP_ENABLED;
              ramp_nxt = `RAMP_NONE;
              by_input_nxt = 1'b0;
            end
          end
        end
        ST_FAULT_REACT: begin
          if (i_motor_stopped) begin
            state_nxt = ST_FAULT;
            ramp_nxt = `RAMP_NONE;
          end
        end
        ST_FAULT: begin
          if (fault_rst_edge && !i_fault) begin
            state_nxt = ST_ON_DISABLED;
          end
        end
        default: begin
          state_nxt = ST_NOT_READY;
          ramp_nxt = `RAMP_NONE;
        end
      endcase
    end
  end

  // ============================================================
  // Status word
  always @* begin
    case (state_r)
      ST_ON_DISABLED: state_bits = 7'h40;
      ST_READY_ON: state_bits = 7'h21;
      ST_SWITCHED_ON: state_bits = 7'h23;
      ST_OP_ENABLED: state_bits = 7'h27;
      ST_OP_STOPPING: state_bits = 7'h27;
      ST_QUICK_STOP: state_bits = 7'h07;
      ST_FAULT_REACT: state_bits = 7'h0f;
      ST_FAULT: state_bits = 7'h08;
      default: state_bits = 7'h00;
    endcase
    status_nxt = 16'h0000;
    status_nxt[6:0] = state_bits;
    status_nxt[`SW_VOLTAGE] = i_voltage_ok;
    status_nxt[`SW_WARNING] = i_warning;
    status_nxt[`SW_MFR_LOW] = i_mfr_bits[0];
    status_nxt[`SW_REMOTE] = init_done_r;
    status_nxt[`SW_TARGET] = i_target_reached;
    status_nxt[`SW_INT_LIMIT] = i_int_limit;
    status_nxt[`SW_MODE_LOW] = i_mode_bits[0];
    status_nxt[`SW_MODE_HIGH] = i_mode_bits[1];
    status_nxt[`SW_MFR_MID] = i_mfr_bits[1];
    status_nxt[`SW_MFR_HIGH] = i_mfr_bits[2];
  end

  // ============================================================
  // Object read and error answer
  always @* begin
    rdata_nxt = 16'h0000;
    err_nxt = 1'b0;
    case (i_obj_index)
      `IDX_DRIVE_STATE_REPORT: begin
        rdata_nxt = o_status_word;
        err_nxt = i_obj_wr;
      end
      `IDX_QUICK_STOP_ACTION: begin
        rdata_nxt = qs_code;
        err_nxt = qs_rej;
      end
      `IDX_SHUTDOWN_ACTION: begin
        rdata_nxt = sd_code;
        err_nxt = sd_rej;
      end
      `IDX_DISABLE_OP_ACTION: begin
        rdata_nxt = do_code;
        err_nxt = do_rej;
      end
      `IDX_HALT_ACTION: begin
        rdata_nxt = halt_code;
        err_nxt = halt_rej;
      end
      default: begin
        err_nxt = 1'b1;
      end
    endcase
  end

  // ============================================================
  // Registers
  always @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_r <= ST_NOT_READY;
      ramp_r <= `RAMP_NONE;
      by_input_r <= 1'b0;
      qs_code_r <= 3'h2;
      to_ready_r <= 1'b0;
      init_done_r <= 1'b0;
      fault_rst_prev_r <= 1'b0;
      o_status_word <= 16'h0000;
      o_obj_rdata <= 16'h0000;
      o_obj_ack <= 1'b0;
      o_obj_err <= 1'b0;
      o_excite <= 1'b0;
      o_stop_req <= 1'b0;
      o_ramp_sel <= `RAMP_NONE;
      o_alarm_reset <= 1'b0;
    end else begin
      state_r <= state_nxt;
      ramp_r <= ramp_nxt;
      by_input_r <= by_input_nxt;
      qs_code_r <= qs_code_nxt;
      to_ready_r <= to_ready_nxt;
      // Sticky: once initialized the drive stays remote-ready
      if (i_init_done) begin
        init_done_r <= 1'b1;
      end
      fault_rst_prev_r <= i_ctrl_word[`CW_FAULT_RESET];
      o_alarm_reset <= fault_rst_edge;
      o_status_word <= status_nxt;
      o_obj_ack <= i_obj_req;
      o_obj_err <= i_obj_req && err_nxt;
      if (i_obj_req) begin
        o_obj_rdata <= i_obj_wr ? 16'h0000 : rdata_nxt;
      end
      o_excite <= (state_nxt == ST_OP_ENABLED) ||
        (state_nxt == ST_OP_STOPPING) || (state_nxt == ST_QUICK_STOP) ||
        (state_nxt == ST_FAULT_REACT);
      o_stop_req <= (ramp_nxt != `RAMP_NONE);
      o_ramp_sel <= ramp_nxt;
    end
  end

endmodule

// ==== verif/fieldbus_master.sv ====
// Behavioural fieldbus master: control word and object accesses.
// Assumes the drive answers each request with a one-cycle ack.
`timescale 1ns/1ps
module fieldbus_master (
  input wire i_clk_sys,
  input wire i_obj_ack,
  input wire i_obj_err,
  input wire [15:0] i_obj_rdata,
  output reg [15:0] o_ctrl_word,
  output reg o_obj_req,
  output reg o_obj_wr,
  output reg [15:0] o_obj_index,
  output reg [15:0] o_obj_wdata
);
  initial begin
    o_ctrl_word = 16'h0000;
    o_obj_req = 1'b0;
    o_obj_wr = 1'b0;
    o_obj_index = 16'h0000;
    o_obj_wdata = 16'h0000;
  end

  task set_cw(input [15:0] v);
    o_ctrl_word = v;
  endtask

  // ============================================================
  // Object access
  // Index and data are inverted once released so stale values never match
  task access(input wr, input [15:0] i, input [15:0] wd,
      output [15:0] rd, output er, output ok);
    integer n;
    begin
      @(posedge i_clk_sys);
      #1;
      o_obj_req = 1'b1;
      o_obj_wr = wr;
      o_obj_index = i;
      o_obj_wdata = wd;
      @(posedge i_clk_sys);
      #1;
      o_obj_req = 1'b0;
      o_obj_index = ~i;
      o_obj_wdata = ~wd;
      ok = 1'b0;
      for (n = 0; n < 3 && !ok; n = n + 1) begin
        if (i_obj_ack === 1'b1) begin
          ok = 1'b1;
          rd = i_obj_rdata;
          er = i_obj_err;
        end else begin
          @(posedge i_clk_sys);
          #1;
        end
      end
    end
  endtask
endmodule

// ==== verif/drive_status_stop_monitor.sv ====
// Concurrent checks on the drive status and stop-action ports.
// Assumes one clock domain with an asynchronous active-low reset.
`timescale 1ns/1ps
module drive_status_stop_monitor (
  input wire i_clk_sys,
  input wire i_rst_b,
  input wire [15:0] i_ctrl_word,
  input wire i_obj_req,
  input wire i_obj_wr,
  input wire [15:0] i_obj_index,
  input wire i_init_done,
  input wire i_fault,
  input wire i_warning,
  input wire i_int_limit,
  input wire i_target_reached,
  input wire [1:0] i_mode_bits,
  input wire i_stop_input,
  input wire i_motor_stopped,
  input wire [15:0] o_status_word,
  input wire o_obj_ack,
  input wire o_obj_err,
  input wire o_excite,
  input wire o_stop_req,
  input wire [1:0] o_ramp_sel,
  input wire o_alarm_reset
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);

  // ============================================================
  // Sequences
  sequence ro_write_s;
    i_obj_req && i_obj_wr && i_obj_index == 16'h6041;
  endsequence
  sequence halt_cmd_s;
    o_status_word[6:0] == 7'h27 && i_ctrl_word[8] &&
    i_ctrl_word[3:0] == 4'hf && !i_stop_input && !i_fault &&
    !i_motor_stopped;
  endsequence
  sequence alarm_pulse_s;
    o_alarm_reset ##1 !o_alarm_reset;
  endsequence

  // ============================================================
  // Assertions
  ro_write_a: assert property (
    ro_write_s |=> o_obj_ack && o_obj_err)
    else $error("status write not refused");
  warn_bit_a: assert property (
    $past(i_rst_b) |-> o_status_word[7] == $past(i_warning))
    else $error("warning bit does not follow");
  init_hold_a: assert property (
    $rose(o_status_word[9]) |-> $past(i_init_done) ||
    $past(i_init_done, 2)) else $error("remote bit set early");
  init_keep_a: assert property (
    o_status_word[9] |=> o_status_word[9])
    else $error("remote bit dropped");
  limit_bit_a: assert property (
    $past(i_rst_b) |-> o_status_word[11] == $past(i_int_limit))
    else $error("limit bit does not follow");
  mode_bits_a: assert property (
    $past(i_rst_b) |-> o_status_word[10] == $past(i_target_reached) &&
    o_status_word[13:12] == $past(i_mode_bits))
    else $error("mode bits do not follow");
  // A stop ramp is only ever run with the motor excited
  stop_level_a: assert property (
    o_stop_req == (o_ramp_sel != 2'h0) && (!o_stop_req || o_excite))
    else $error("stop request without excited ramp");
  halt_stays_a: assert property (
    halt_cmd_s |=> o_stop_req && o_excite ##1 o_status_word[2])
    else $error("halt left operation enabled");
  alarm_pulse_a: assert property (
    $rose(i_ctrl_word[7]) |=> alarm_pulse_s)
    else $error("alarm reset pulse wrong");
endmodule

bind drive_status_stop drive_status_stop_monitor mon_u (
  .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_ctrl_word(i_ctrl_word),
  .i_obj_req(i_obj_req), .i_obj_wr(i_obj_wr), .i_obj_index(i_obj_index),
  .i_init_done(i_init_done), .i_fault(i_fault), .i_warning(i_warning),
  .i_int_limit(i_int_limit), .i_target_reached(i_target_reached),
  .i_mode_bits(i_mode_bits), .i_stop_input(i_stop_input),
  .i_motor_stopped(i_motor_stopped), .o_status_word(o_status_word),
  .o_obj_ack(o_obj_ack), .o_obj_err(o_obj_err), .o_excite(o_excite),
  .o_stop_req(o_stop_req), .o_ramp_sel(o_ramp_sel),
  .o_alarm_reset(o_alarm_reset)
);

// ==== verif/test_drive_status_stop.sv ====
// Bench for the drive status and stop-action block.
// Assumes fieldbus_master drives the control word and object port.
`timescale 1ns/1ps
module test_drive_status_stop;
  reg clk, rst_b, init, fault, warn, volt, lim, tgt, stp_in, stopped;
  reg [1:0] mode;
  reg [2:0] mfr;
  reg [15:0] rd;
  reg er, ok;
  wire [15:0] cw, idx, wdat, status, rdata;
  wire [1:0] ramp;
  wire req, wr, ack, err, excite, stop_req, alarm;
  integer n_mismatch, checks, c;

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  drive_status_stop dut_u (.i_clk_sys(clk), .i_rst_b(rst_b),
    .i_ctrl_word(cw), .i_obj_req(req), .i_obj_wr(wr), .i_obj_index(idx),
    .i_obj_wdata(wdat), .i_init_done(init), .i_fault(fault),
    .i_warning(warn), .i_voltage_ok(volt), .i_int_limit(lim),
    .i_target_reached(tgt), .i_mode_bits(mode), .i_mfr_bits(mfr),
    .i_stop_input(stp_in), .i_motor_stopped(stopped),
    .o_status_word(status), .o_obj_rdata(rdata), .o_obj_ack(ack),
    .o_obj_err(err), .o_excite(excite), .o_stop_req(stop_req),
    .o_ramp_sel(ramp), .o_alarm_reset(alarm));
  fieldbus_master m_u (.i_clk_sys(clk), .i_obj_ack(ack), .i_obj_err(err),
    .i_obj_rdata(rdata), .o_ctrl_word(cw), .o_obj_req(req), .o_obj_wr(wr),
    .o_obj_index(idx), .o_obj_wdata(wdat));

  // ============================================================
  // Shared tasks
  task cyc(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  task chk(input [79:0] nm, input [15:0] exp, input [15:0] got);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("MISMATCH %0s exp %h got %h", nm, exp, got);
      end
    end
  endtask
  task wo(input [15:0] i, input [15:0] v, input e);
    begin
      m_u.access(1'b1, i, v, rd, er, ok);
      chk("wr_answer", {14'h0, 1'b1, e}, {14'h0, ok, er});
    end
  endtask
  task ro(input [15:0] i, input [15:0] v);
    begin
      m_u.access(1'b0, i, 16'h0000, rd, er, ok);
      chk("rd_answer", 16'h0002, {14'h0, ok, er});
      chk("rd_data", v, rd);
    end
  endtask
  // State 7'h7f means the state is not judged
  task cmd(input [15:0] v, input [6:0] s);
    begin
      m_u.set_cw(v);
      cyc(3);
      if (s != 7'h7f)
        chk("state", {9'h0, s}, {9'h0, status[6:0]});
    end
  endtask
  task go_op;
    begin
      cmd(16'h0000, 7'h40);
      stopped = 1'b0;
      stp_in = 1'b0;
      cmd(16'h0006, 7'h21);
      cmd(16'h0007, 7'h23);
      cmd(16'h000f, 7'h27);
    end
  endtask
  task sweep(input [15:0] i, input [15:0] okset, input [15:0] rv);
    integer v;
    reg [15:0] cur;
    begin
      cur = rv;
      for (v = 0; v < 9; v = v + 1) begin
        wo(i, v[15:0], ~okset[v]);
        if (okset[v])
          cur = v[15:0];
        ro(i, cur);
      end
      wo(i, rv, 1'b0);
    end
  endtask

  // ============================================================
  // Scenarios
  task t_flags;
    begin
      warn = 1'b1;
      lim = 1'b1;
      tgt = 1'b1;
      volt = 1'b1;
      mode = 2'b10;
      mfr = 3'b101;
      cyc(3);
      chk("flags_on", 16'had90, status & 16'hfd90);
      warn = 1'b0;
      cyc(3);
      chk("warn_off", 16'had10, status & 16'hfd90);
      lim = 1'b0;
      tgt = 1'b0;
      volt = 1'b0;
      mode = 2'b01;
      mfr = 3'b010;
      cyc(3);
      chk("flags_swap", 16'h5000, status & 16'hfd90);
      mode = 2'b00;
      mfr = 3'b000;
    end
  endtask
  task t_qstop;
    begin
      for (c = 0; c < 8; c = c + 1) begin
        if (c != 4) begin
          wo(16'h605a, c[15:0], 1'b0);
          go_op;
          cmd(16'h000b, (c == 0) ? 7'h40 : 7'h07);
          chk("qs_excite", {15'h0, c != 0}, {15'h0, excite});
          wo(16'h605a, 16'h0002, 1'b0);
          chk("qs_ramp", {14'h0, c[1:0]}, {14'h0, ramp});
          stopped = 1'b1;
          cyc(3);
          chk("qs_end", (c > 4) ? 16'h7 : 16'h40,
            {9'h0, status[6:0]});
        end
      end
    end
  endtask
  task t_ramps;
    begin
      go_op;
      cmd(16'h0006, 7'h27);
      chk("sd_ramp", 16'h1, {14'h0, ramp});
      cmd(16'h0002, 7'h7f);
      chk("qs_switch", 16'h2, {14'h0, ramp});
      wo(16'h605b, 16'h0000, 1'b0);
      go_op;
      cmd(16'h0006, 7'h21);
      chk("sd_excite", 16'h0, {15'h0, excite});
      wo(16'h605b, 16'h0001, 1'b0);
      go_op;
      cmd(16'h0007, 7'h7f);
      chk("do_ramp", 16'h1, {14'h0, ramp});
      stopped = 1'b1;
      cyc(3);
      chk("do_end", 16'h23, {9'h0, status[6:0]});
      chk("do_excite", 16'h0, {15'h0, excite});
      wo(16'h605c, 16'h0000, 1'b0);
      go_op;
      cmd(16'h0007, 7'h23);
      chk("do0_excite", 16'h0, {15'h0, excite});
      wo(16'h605c, 16'h0001, 1'b0);
      go_op;
      // The stop input must have started its ramp before the quick stop
      stp_in = 1'b1;
      cmd(16'h000f, 7'h27);
      chk("in_ramp", 16'h1, {14'h0, ramp});
      cmd(16'h000b, 7'h7f);
      chk("stop_in", 16'h1, {14'h0, ramp});
    end
  endtask
  task t_halt;
    integer h;
    begin
      go_op;
      for (h = 1; h < 4; h = h + 1) begin
        wo(16'h605d, h[15:0], 1'b0);
        cmd(16'h010f, 7'h27);
        chk("halt_ramp", h[15:0], {14'h0, ramp});
        cmd(16'h000f, 7'h27);
        chk("halt_off", 16'h0, {14'h0, ramp});
      end
    end
  endtask
  task t_fault;
    begin
      go_op;
      fault = 1'b1;
      stopped = 1'b1;
      cyc(4);
      chk("fault", 16'h8, {9'h0, status[6:0]});
      fault = 1'b0;
      m_u.set_cw(16'h008f);
      cyc(1);
      chk("alarm_rst", 16'h1, {15'h0, alarm});
      cyc(2);
      chk("cleared", 16'h40, {9'h0, status[6:0]});
    end
  endtask

  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask

  // Ten thousand cycles is several times the expected run length
  initial begin
    #200000;
    n_mismatch = n_mismatch + 1;
    print_verdict;
  end

  initial begin
    n_mismatch = 0;
    checks = 0;
    {rst_b, init, fault, warn, volt, lim, tgt, stp_in, stopped} = 9'h0;
    mode = 2'b00;
    mfr = 3'b000;
    cyc(3);
    rst_b = 1'b1;
    cyc(4);
    chk("remote_lo", 16'h0000, status);
    init = 1'b1;
    cyc(4);
    chk("remote_hi", 16'h0240, status);
    ro(16'h6041, 16'h0240);
    ro(16'h605a, 16'h0002);
    ro(16'h605b, 16'h0001);
    ro(16'h605c, 16'h0001);
    ro(16'h605d, 16'h0001);
    wo(16'h6041, 16'h0000, 1'b1);
    wo(16'h6042, 16'h0001, 1'b1);
    sweep(16'h605a, 16'h00ef, 16'h0002);
    sweep(16'h605b, 16'h0003, 16'h0001);
    sweep(16'h605c, 16'h0003, 16'h0001);
    sweep(16'h605d, 16'h000e, 16'h0001);
    t_flags;
    t_qstop;
    t_ramps;
    t_halt;
    t_fault;
    print_verdict;
  end
endmodule
